/* include/tcu_pkg.sv */
// package for the 16-bit timer counter and input capture block
// assumes an 8-bit cpu register port on the same clock as the timer
`default_nettype none
package tcu_pkg;
  // ----------------------------------------------------------------
  // register selects on the cpu port
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_COUNT_LO = 3'h0;
  localparam logic [2:0] SEL_COUNT_HI = 3'h1;
  localparam logic [2:0] SEL_CAPT_LO = 3'h2;
  localparam logic [2:0] SEL_CAPT_HI = 3'h3;
  localparam logic [2:0] SEL_CTRL_A = 3'h4;
  localparam logic [2:0] SEL_CTRL_B = 3'h5;
  localparam logic [2:0] SEL_FLAGS = 3'h6;
  localparam logic [2:0] SEL_CMP_CTRL = 3'h7;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRLA_WGM_LO = 0;
  localparam int CTRLB_CS_LO = 0;
  localparam int CTRLB_WGM_HI = 3;
  localparam int CTRLB_EDGE = 6;
  localparam int CTRLB_FILT = 7;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CAPT = 5;
  localparam int CMP_TRIG_SEL = 2;
  localparam int IRQEN_CAPT = 5;
  localparam int IRQEN_OVF = 0;
  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam int FILTER_SAMPLES = 4;
  localparam int SYNC_STAGES = 3;
  // waveform mode codes; 8, a, c and e take the capture register as top
  localparam logic [3:0] WGM_PFC_ICR = 4'h8;
  localparam logic [3:0] WGM_PC_ICR = 4'ha;
  localparam logic [3:0] WGM_CTC_ICR = 4'hc;
  localparam logic [3:0] WGM_FAST_ICR = 4'he;
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_OCR = 4'h4;
endpackage
`default_nettype wire

/* verilog/tcu_sync.sv */
// three-stage synchronizer for an asynchronous level
// assumes input unrelated to core_clk_i
`default_nettype none
module tcu_sync (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic level_o
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } tcu_sync_s;
  tcu_sync_s st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.stage = {st_reg.stage[1:0], async_i};
    // change accepted once stages two and three agree
    if (st_reg.stage[1] == st_reg.stage[2]) begin
      st_next.level = st_reg.stage[2];
    end
  end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next; // [RULE_24]
    end
  end
  assign level_o = st_reg.level;
endmodule
`default_nettype wire

/* verilog/tcu_filter.sv */
// four-sample noise filter plus edge detector on the system clock
// assumes a synchronized input
`default_nettype none
module tcu_filter #(
  parameter int SAMPLES = tcu_pkg::FILTER_SAMPLES
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic in_i,
  input wire logic filt_en_i,
  input wire logic active_i,
  input wire logic rising_i,
  output logic edge_o
);
  initial begin
    if (SAMPLES < 2) begin
      $error("tcu_filter: SAMPLES must be at least 2");
    end
  end
  typedef struct packed {
    logic [SAMPLES-1:0] hist;
    logic filt;
    logic prev;
  } tcu_filter_s;
  tcu_filter_s st_reg, st_next;
  logic src;
  always_comb begin
    st_next = st_reg;
    st_next.hist = {st_reg.hist[SAMPLES-2:0], in_i};
    // output moves only on a full run of equal samples
    if (&st_reg.hist) begin
      st_next.filt = 1'b1; // [RULE_20]
    end else if (~|st_reg.hist) begin
      st_next.filt = 1'b0; // [RULE_20]
    end
    src = filt_en_i ? st_reg.filt : in_i; // [RULE_23]
    st_next.prev = src;
  end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // edge in chosen direction; gated off when capture holds top
  assign edge_o = active_i & (src != st_reg.prev) & (src == rising_i); // [RULE_12] [RULE_21]
endmodule
`default_nettype wire

/* verilog/tcu_timer16.sv */
// counter core and input capture of a 16-bit timer on an 8-bit cpu port
// assumes a one-cycle cpu read/write strobe and an external prescaler tick
// Overview of operation
// [RULE_01] count strobe moves counter by exactly one, up or down by direction
// [RULE_02] clear forces every counter bit to zero
// [RULE_03] max indication at all ones, zero indication at zero; the max output here compares against top_value
// [RULE_04] high-byte location accesses the shared temporary register
// [RULE_05] low-byte counter read copies counter high byte into temporary
// [RULE_06] low-byte counter write loads high byte from temporary, same cycle
// [RULE_07] each tick clears, increments or decrements as the mode requires
// [RULE_08] clock select zero stops the tick; cpu access still works
// [RULE_09] cpu counter write beats clear and count in the same cycle
// [RULE_10] four-bit waveform mode split across control a and b selects sequence
// [RULE_11] overflow flag set per mode and may request an interrupt
// [RULE_12] capture on chosen edge of pin or comparator output
// [RULE_13] capture copies the full 16-bit counter into capture register
// [RULE_14] capture flag set in the cycle the counter is copied
// [RULE_15] enabled flag requests irq; cleared by irq ack or writing one
// [RULE_16] capture low read first copies high byte into temporary
// [RULE_17] capture register writable only when mode uses it as top
// [RULE_18] software sets mode first and writes high byte before low
// [RULE_19] trigger select picks comparator; software clears flag after switching
// [RULE_20] filter output changes after four equal samples
// [RULE_21] filter and edge input active except when capture holds top
// [RULE_22] software driving the capture pin captures like an external event
// [RULE_23] filter enabled by a control b bit, runs on system clock
// [RULE_24] pin and comparator inputs synchronized before filter
`default_nettype none
module tcu_timer16 (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic prescale_tick_i,
  input wire logic capture_pin_i,
  input wire logic comparator_output_i,
  input wire logic capture_irq_ack_i,
  input wire logic overflow_irq_ack_i,
  input wire logic [7:0] irq_enable_i,
  output logic capture_irq_o,
  output logic overflow_irq_o,
  output logic count_max_reached_o,
  output logic count_zero_reached_o,
  output logic [15:0] count_value_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCU_UP = 2'b01,
    TCU_DOWN = 2'b10
  } tcu_dir_e;
  typedef struct packed {
    logic [15:0] count_value;
    logic [15:0] capture_value;
    logic [7:0] temp;
    logic [7:0] timer_control_a;
    logic [7:0] timer_control_b;
    logic [7:0] comparator_control_status;
    logic overflow_flag;
    logic capture_flag;
    tcu_dir_e dir;
    logic [7:0] rdata;
  } tcu_timer_s;
  tcu_timer_s st_reg, st_next;

  logic pin_sync, cmp_sync, edge_hit, timer_tick, top_is_capt;
  logic [3:0] waveform_mode_field;
  logic [2:0] clock_select_field;
  logic [15:0] top_value;
  logic cpu_wr_count;

  function automatic logic capt_is_top(input logic [3:0] wgm);
    capt_is_top = (wgm == tcu_pkg::WGM_PFC_ICR) || (wgm == tcu_pkg::WGM_PC_ICR) ||
                  (wgm == tcu_pkg::WGM_CTC_ICR) || (wgm == tcu_pkg::WGM_FAST_ICR);
  endfunction

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  // pin path sees the pad itself, so a port-driven level captures too [RULE_22]
  tcu_sync u_sync_pin (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .async_i(capture_pin_i),
    .level_o(pin_sync)
  );
  tcu_sync u_sync_cmp (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .async_i(comparator_output_i),
    .level_o(cmp_sync)
  );
  tcu_filter #(
    .SAMPLES(tcu_pkg::FILTER_SAMPLES)
  ) u_filter (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .in_i(st_reg.comparator_control_status[tcu_pkg::CMP_TRIG_SEL] ? cmp_sync : pin_sync), // [RULE_19]
    .filt_en_i(st_reg.timer_control_b[tcu_pkg::CTRLB_FILT]), // [RULE_23]
    .active_i(!top_is_capt), // [RULE_21]
    .rising_i(st_reg.timer_control_b[tcu_pkg::CTRLB_EDGE]),
    .edge_o(edge_hit)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign waveform_mode_field = {st_reg.timer_control_b[tcu_pkg::CTRLB_WGM_HI +: 2],
                                st_reg.timer_control_a[tcu_pkg::CTRLA_WGM_LO +: 2]}; // [RULE_10]
  assign clock_select_field = st_reg.timer_control_b[tcu_pkg::CTRLB_CS_LO +: 3];
  // prescaler lives outside; select zero gates the tick off
  assign timer_tick = (clock_select_field != 3'h0) && prescale_tick_i; // [RULE_08]
  assign top_is_capt = capt_is_top(waveform_mode_field);
  // compare-register top modes are not part of this block; they run to max
  assign top_value = top_is_capt ? st_reg.capture_value : tcu_pkg::COUNT_MAX;
  assign cpu_wr_count = reg_wr_i && (reg_sel_i == tcu_pkg::SEL_COUNT_LO);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic dual_slope;
    logic clear_now;
    logic ovf_now;
    dual_slope = 1'b0;
    clear_now = 1'b0;
    ovf_now = 1'b0;
    st_next = st_reg;
    dual_slope = (waveform_mode_field == tcu_pkg::WGM_PFC_ICR) || (waveform_mode_field == tcu_pkg::WGM_PC_ICR);

    // counter sequence per mode
    if (timer_tick) begin // [RULE_07]
      if (dual_slope) begin
        unique case (st_reg.dir)
          TCU_UP: begin
            if (st_reg.count_value >= top_value) begin
              st_next.dir = TCU_DOWN;
              st_next.count_value = st_reg.count_value - 16'h0001; // [RULE_01]
            end else begin
              st_next.count_value = st_reg.count_value + 16'h0001; // [RULE_01]
            end
          end
          TCU_DOWN: begin
            if (st_reg.count_value == tcu_pkg::RST_WORD) begin
              st_next.dir = TCU_UP;
              st_next.count_value = st_reg.count_value + 16'h0001;
              ovf_now = 1'b1; // overflow at count_zero_reached in dual slope [RULE_11]
            end else begin
              st_next.count_value = st_reg.count_value - 16'h0001; // [RULE_01]
            end
          end
          default: begin
            st_next.dir = TCU_UP;
          end
        endcase
      end else begin
        st_next.dir = TCU_UP;
        clear_now = (st_reg.count_value == top_value);
        if (clear_now) begin
          st_next.count_value = tcu_pkg::RST_WORD; // [RULE_02]
          // ctc mode wraps silently unless top is the max value
          ovf_now = (waveform_mode_field != tcu_pkg::WGM_CTC_ICR) || (top_value == tcu_pkg::COUNT_MAX); // [RULE_11]
        end else begin
          st_next.count_value = st_reg.count_value + 16'h0001; // [RULE_01]
        end
      end
    end

    // capture; written value from cpu in top modes wins over nothing since edge is gated there
    if (edge_hit) begin
      st_next.capture_value = st_reg.count_value; // [RULE_13]
    end

    // flags: ack or write-one clears, a same-cycle set wins
    if (capture_irq_ack_i) begin
      st_next.capture_flag = 1'b0; // [RULE_15]
    end
    if (overflow_irq_ack_i) begin
      st_next.overflow_flag = 1'b0;
    end

    // cpu writes
    if (reg_wr_i) begin
      unique case (reg_sel_i)
        tcu_pkg::SEL_COUNT_LO: begin
          st_next.count_value = {st_reg.temp, reg_wdata_i}; // [RULE_06] [RULE_09]
        end
        tcu_pkg::SEL_COUNT_HI, tcu_pkg::SEL_CAPT_HI: begin
          st_next.temp = reg_wdata_i; // [RULE_04]
        end
        tcu_pkg::SEL_CAPT_LO: begin
          if (top_is_capt) begin
            st_next.capture_value = {st_reg.temp, reg_wdata_i}; // [RULE_17] [RULE_18]
          end
        end
        tcu_pkg::SEL_CTRL_A: begin
          st_next.timer_control_a = reg_wdata_i;
        end
        tcu_pkg::SEL_CTRL_B: begin
          st_next.timer_control_b = reg_wdata_i;
        end
        tcu_pkg::SEL_FLAGS: begin
          if (reg_wdata_i[tcu_pkg::FLAG_CAPT]) begin
            st_next.capture_flag = 1'b0; // [RULE_15] [RULE_19]
          end
          if (reg_wdata_i[tcu_pkg::FLAG_OVF]) begin
            st_next.overflow_flag = 1'b0;
          end
        end
        tcu_pkg::SEL_CMP_CTRL: begin
          st_next.comparator_control_status = reg_wdata_i; // [RULE_19]
        end
        default: begin
        end
      endcase
    end

    // cpu reads
    st_next.rdata = tcu_pkg::RST_BYTE;
    if (reg_rd_i) begin
      unique case (reg_sel_i)
        tcu_pkg::SEL_COUNT_LO: begin
          st_next.rdata = st_reg.count_value[7:0];
          if (!reg_wr_i) begin
            st_next.temp = st_reg.count_value[15:8]; // [RULE_05]
          end
        end
        tcu_pkg::SEL_CAPT_LO: begin
          st_next.rdata = st_reg.capture_value[7:0];
          if (!reg_wr_i) begin
            st_next.temp = st_reg.capture_value[15:8]; // [RULE_16]
          end
        end
        tcu_pkg::SEL_COUNT_HI, tcu_pkg::SEL_CAPT_HI: begin
          st_next.rdata = st_reg.temp; // [RULE_04] [RULE_16]
        end
        tcu_pkg::SEL_CTRL_A: begin
          st_next.rdata = st_reg.timer_control_a;
        end
        tcu_pkg::SEL_CTRL_B: begin
          st_next.rdata = st_reg.timer_control_b;
        end
        tcu_pkg::SEL_FLAGS: begin
          st_next.rdata[tcu_pkg::FLAG_CAPT] = st_reg.capture_flag;
          st_next.rdata[tcu_pkg::FLAG_OVF] = st_reg.overflow_flag;
        end
        tcu_pkg::SEL_CMP_CTRL: begin
          st_next.rdata = st_reg.comparator_control_status;
        end
        default: begin
        end
      endcase
    end

    // hardware sets last so they win over clears
    if (edge_hit) begin
      st_next.capture_flag = 1'b1; // [RULE_14]
    end
    if (ovf_now && !cpu_wr_count) begin
      st_next.overflow_flag = 1'b1; // [RULE_11]
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '{count_value: 16'h0000, capture_value: 16'h0000, temp: 8'h00,
                  timer_control_a: 8'h00, timer_control_b: 8'h00,
                  comparator_control_status: 8'h00, overflow_flag: 1'b0,
                  capture_flag: 1'b0, dir: TCU_UP, rdata: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = st_reg.rdata;
  assign count_value_o = st_reg.count_value;
  assign count_max_reached_o = (st_reg.count_value == top_value); // [RULE_03]
  assign count_zero_reached_o = (st_reg.count_value == tcu_pkg::RST_WORD); // [RULE_03]
  assign capture_irq_o = st_reg.capture_flag & irq_enable_i[tcu_pkg::IRQEN_CAPT]; // [RULE_15]
  assign overflow_irq_o = st_reg.overflow_flag & irq_enable_i[tcu_pkg::IRQEN_OVF]; // [RULE_11]
endmodule
`default_nettype wire

/* sim/tcu_timer16_checker.sv */
// checker on the ports of the timer counter and capture block
// assumes one clock domain and the registered read data of the cpu port
`default_nettype none
module tcu_timer16_checker (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic prescale_tick_i,
  input wire logic capture_irq_ack_i,
  input wire logic [7:0] irq_enable_i,
  input wire logic capture_irq_o,
  input wire logic overflow_irq_o,
  input wire logic count_zero_reached_o,
  input wire logic [15:0] count_value_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  a_zero_ind: assert property (count_zero_reached_o == (count_value_o == 16'h0000))
    else $error("zero indication wrong");
  a_lo_write: assert property (reg_wr_i && reg_sel_i == tcu_pkg::SEL_COUNT_LO
    |=> count_value_o[7:0] == $past(reg_wdata_i)) else $error("low byte write lost");
  a_hi_write: assert property (reg_wr_i && reg_sel_i == tcu_pkg::SEL_COUNT_HI && !prescale_tick_i
    |=> $stable(count_value_o)) else $error("high byte write reached counter");
  a_no_tick: assert property (!prescale_tick_i && !(reg_wr_i && reg_sel_i == tcu_pkg::SEL_COUNT_LO)
    |=> $stable(count_value_o)) else $error("counter moved without tick");
  a_step_one: assert property (prescale_tick_i && !(reg_wr_i && reg_sel_i == tcu_pkg::SEL_COUNT_LO)
    |=> count_value_o == $past(count_value_o) + 16'h0001 || count_value_o == $past(count_value_o) - 16'h0001
    || count_value_o == 16'h0000 || $stable(count_value_o)) else $error("counter step not one");
  // ----------------------------------------------------------------
  // cpu reads and flags
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_rd_lo: assert property (reg_rd_i && reg_sel_i == tcu_pkg::SEL_COUNT_LO
    |=> reg_rdata_o == $past(count_value_o[7:0])) else $error("count low read wrong");
  a_temp_hi: assert property (reg_rd_i && reg_sel_i == tcu_pkg::SEL_COUNT_LO ##1 !reg_wr_i && !reg_rd_i
    ##1 reg_rd_i && reg_sel_i == tcu_pkg::SEL_COUNT_HI |=> reg_rdata_o == $past(count_value_o[15:8], 3))
    else $error("temporary high byte wrong");
  a_ovf_en: assert property (overflow_irq_o |-> irq_enable_i[0])
    else $error("overflow request while disabled");
  a_capt_en: assert property (capture_irq_o |-> irq_enable_i[5])
    else $error("capture request while disabled");
  a_capt_hold: assert property (capture_irq_o && !capture_irq_ack_i
    && !(reg_wr_i && reg_sel_i == tcu_pkg::SEL_FLAGS && reg_wdata_i[5])
    |=> capture_irq_o || !irq_enable_i[5]) else $error("capture flag dropped");
endmodule
bind tcu_timer16 tcu_timer16_checker tcu_timer16_checker_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .prescale_tick_i(prescale_tick_i), .capture_irq_ack_i(capture_irq_ack_i),
  .irq_enable_i(irq_enable_i), .capture_irq_o(capture_irq_o), .overflow_irq_o(overflow_irq_o),
  .count_zero_reached_o(count_zero_reached_o), .count_value_o(count_value_o));
`default_nettype wire

/* sim/tcu_cpu_model.sv */
// cpu side model: byte strobes on the 8-bit register port
// assumes strobes are sampled on the rising edge and driven at the falling edge
`default_nettype none
module tcu_cpu_model (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [2:0] reg_sel_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_sel_o = 3'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // released lines show the inverse so a stale value never passes
  task automatic wr_reg(input logic [2:0] sel, input logic [7:0] data);
    @(negedge core_clk_i);
    reg_sel_o = sel;
    reg_wdata_o = data;
    reg_wr_o = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~data;
    reg_sel_o = ~sel;
  endtask
  task automatic rd_reg(input logic [2:0] sel, output logic [7:0] data);
    @(negedge core_clk_i);
    reg_sel_o = sel;
    reg_rd_o = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    data = reg_rdata_i;
    reg_sel_o = ~sel;
  endtask
  // high byte goes to the shared temporary first
  task automatic wr16(input logic [2:0] lo_sel, input logic [15:0] value);
    wr_reg(lo_sel + 3'h1, value[15:8]);
    wr_reg(lo_sel, value[7:0]);
  endtask
  task automatic rd16(input logic [2:0] lo_sel, output logic [15:0] value);
    rd_reg(lo_sel, value[7:0]);
    rd_reg(lo_sel + 3'h1, value[15:8]);
  endtask
endmodule
`default_nettype wire

/* sim/tcu_timer16_bench.sv */
// self-checking bench for the timer counter and capture block
// assumes the cpu model drives the register port, the bench the rest
`default_nettype none
module tcu_timer16_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] reg_sel;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic tick = 1'b0;
  logic pin = 1'b0;
  logic cmp = 1'b0;
  logic capt_ack = 1'b0;
  logic ovf_ack = 1'b0;
  logic [7:0] irq_en = 8'h21;
  logic capt_irq;
  logic ovf_irq;
  logic max_ind;
  logic zero_ind;
  logic [15:0] count;
  logic [15:0] v;
  logic [7:0] b;
  int miscompares = 0;
  int n_compared = 0;
  initial forever #12.5 core_clk_i = ~core_clk_i;
  tcu_cpu_model tcu_cpu_model_i (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata), .reg_sel_o(reg_sel),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata));
  tcu_timer16 tcu_timer16_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_sel_i(reg_sel), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .prescale_tick_i(tick),
    .capture_pin_i(pin), .comparator_output_i(cmp), .capture_irq_ack_i(capt_ack),
    .overflow_irq_ack_i(ovf_ack), .irq_enable_i(irq_en), .capture_irq_o(capt_irq), .overflow_irq_o(ovf_irq),
    .count_max_reached_o(max_ind), .count_zero_reached_o(zero_ind), .count_value_o(count));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge core_clk_i);
      tick = 1'b1;
      @(negedge core_clk_i);
      tick = 1'b0;
    end
  endtask
  // covers the synchronizer and filter latency with margin
  task automatic settle();
    repeat (16) @(negedge core_clk_i);
  endtask
  task automatic pulse_ack(input bit capt);
    @(negedge core_clk_i);
    if (capt) begin
      capt_ack = 1'b1;
    end else begin
      ovf_ack = 1'b1;
    end
    @(negedge core_clk_i);
    capt_ack = 1'b0;
    ovf_ack = 1'b0;
  endtask
  initial begin
    #(25ns * 20000);
    miscompares++;
    final_report();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    nrst_i = 1'b1;
    chk("zero_ind", zero_ind, 16'h0001);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_COUNT_HI, 8'h12);
    chk("count", count, 16'h0000);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_COUNT_LO, 8'h34);
    chk("count", count, 16'h1234);
    tcu_cpu_model_i.rd16(tcu_pkg::SEL_COUNT_LO, v);
    chk("count_rd", v, 16'h1234);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_COUNT_HI, 8'h55);
    tcu_cpu_model_i.rd16(tcu_pkg::SEL_COUNT_LO, v);
    chk("count_rd", v, 16'h1234);
    ticks(3);
    chk("count", count, 16'h1234);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_CTRL_B, 8'h01);
    tcu_cpu_model_i.wr16(tcu_pkg::SEL_COUNT_LO, 16'hfffe);
    ticks(1);
    chk("max_ind", max_ind, 16'h0001);
    ticks(1);
    chk("count", count, 16'h0000);
    chk("ovf_irq", ovf_irq, 16'h0001);
    pulse_ack(1'b0);
    chk("ovf_irq", ovf_irq, 16'h0000);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_COUNT_HI, 8'h40);
    tick = 1'b1;
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_COUNT_LO, 8'h10);
    tick = 1'b0;
    chk("count", count, 16'h4010);
    // clear-on-top mode with the capture register as top
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_CTRL_B, 8'h18);
    tcu_cpu_model_i.wr16(tcu_pkg::SEL_CAPT_LO, 16'h0002);
    tcu_cpu_model_i.rd16(tcu_pkg::SEL_CAPT_LO, v);
    chk("capt_rd", v, 16'h0002);
    tcu_cpu_model_i.wr16(tcu_pkg::SEL_COUNT_LO, 16'h0000);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_CTRL_B, 8'h19);
    ticks(2);
    chk("max_ind", max_ind, 16'h0001);
    ticks(1);
    chk("count", count, 16'h0000);
    pin = 1'b1;
    settle();
    chk("capt_irq", capt_irq, 16'h0000);
    pin = 1'b0;
    // dual slope, top 2
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_CTRL_B, 8'h11);
    ticks(3);
    chk("count", count, 16'h0001);
    // down to count_zero_reached and turn: overflow flags at the count_zero_reached in dual slope
    ticks(2);
    chk("count", count, 16'h0001);
    chk("ovf_irq", ovf_irq, 16'h0001);
    // captures with the counter stopped at a known value
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_CTRL_B, 8'h40);
    tcu_cpu_model_i.wr16(tcu_pkg::SEL_COUNT_LO, 16'habcd);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_FLAGS, 8'h21);
    pin = 1'b1;
    settle();
    chk("capt_irq", capt_irq, 16'h0001);
    irq_en = 8'h01;
    @(negedge core_clk_i);
    chk("capt_irq", capt_irq, 16'h0000);
    irq_en = 8'h21;
    tcu_cpu_model_i.rd16(tcu_pkg::SEL_CAPT_LO, v);
    chk("capt_rd", v, 16'habcd);
    tcu_cpu_model_i.wr16(tcu_pkg::SEL_CAPT_LO, 16'h1111);
    tcu_cpu_model_i.rd16(tcu_pkg::SEL_CAPT_LO, v);
    chk("capt_rd", v, 16'habcd);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_FLAGS, 8'h20);
    chk("capt_irq", capt_irq, 16'h0000);
    pin = 1'b0;
    settle();
    chk("capt_irq", capt_irq, 16'h0000);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_CTRL_B, 8'h00);
    pin = 1'b1;
    settle();
    chk("capt_irq", capt_irq, 16'h0000);
    pin = 1'b0;
    settle();
    chk("capt_irq", capt_irq, 16'h0001);
    pulse_ack(1'b1);
    chk("capt_irq", capt_irq, 16'h0000);
    // filter: a two-cycle glitch must not pass
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_CTRL_B, 8'hc0);
    pin = 1'b1;
    repeat (2) @(negedge core_clk_i);
    pin = 1'b0;
    settle();
    chk("capt_irq", capt_irq, 16'h0000);
    pin = 1'b1;
    settle();
    chk("capt_irq", capt_irq, 16'h0001);
    pin = 1'b0;
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_CMP_CTRL, 8'h04);
    settle();
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_FLAGS, 8'h20);
    cmp = 1'b1;
    settle();
    chk("capt_irq", capt_irq, 16'h0001);
    tcu_cpu_model_i.wr_reg(tcu_pkg::SEL_FLAGS, 8'h20);
    pin = 1'b1;
    settle();
    chk("capt_irq", capt_irq, 16'h0000);
    tcu_cpu_model_i.rd_reg(tcu_pkg::SEL_CAPT_HI, b);
    chk("capt_hi", b, 16'h00ab);
    final_report();
  end
endmodule
`default_nettype wire
